/* File: pkg/scs_pkg.sv */
// Constants and types for the system clock source select block
// Notes on behaviour
// - Low-power bit 1 reduces slow crystal current
// - Power-on reset clears the low-power bit
// - Slow crystal keeps running in either mode
// - Pin-share bit gives crystal pins or I/O
// - Slow clock usable only after start-up delay
// - Sleep or idle gates processor clock off
// - Select bit plus divider field pick clock
// - Fast source fixed by configuration option
// - Substitute source fixed by configuration option
// - Fast clock divided by two to sixty-four
// - Substitute and time-base sources by option
// - Fast wake-up runs processor from substitute only when fast source is crystal
// - Substitute selected stops fast clock; divider keeps counting
// - Slow oscillators also clock the time-base
// - Codes 000/001 substitute, then divide 64..2
// - Select bit 1 picks undivided fast clock
// - Ready after 128 crystal or 2 ticks
package scs_pkg;
	localparam logic [7:0] SCS_SYSMODE_OFS = 8'h00;
	localparam logic [7:0] SCS_TIMEBASE_OFS = 8'h04;
	localparam logic [7:0] SCS_PINSHARE_OFS = 8'h08;
	localparam int SCS_HIGH_LOW_CLOCK_SELECT_BIT = 0;
	localparam int SCS_IDLEN_BIT = 1;
	localparam int SCS_FASTRDY_BIT = 2;
	localparam int SCS_SLOWRDY_BIT = 3;
	localparam int SCS_FSTEN_BIT = 4;
	localparam int SCS_CKS_LSB = 5;
	localparam int SCS_LOWPOWER_BIT = 0;
	localparam int SCS_PINXTAL_BIT = 0;
	localparam logic [2:0] SCS_CKS_RESET = 3'h0;
	localparam logic SCS_FSTEN_RESET = 1'b0;
	localparam logic SCS_IDLEN_RESET = 1'b1;
	localparam logic SCS_HIGH_LOW_CLOCK_SELECT_RESET = 1'b1;
	localparam logic SCS_LOWPOWER_RESET = 1'b0;
	localparam logic SCS_PINXTAL_RESET = 1'b0;
	localparam logic [7:0] SCS_SLOW_XTAL_READY_TICKS = 8'h80;
	localparam logic [7:0] SCS_SLOW_RC_READY_TICKS = 8'h02;
	localparam logic [7:0] SCS_FAST_XTAL_READY_CYC = 8'h80;
	localparam logic [7:0] SCS_FAST_RC_READY_CYC = 8'h10;
	typedef enum logic [1:0] {
		SCS_ST_RUN = 2'b00,
		SCS_ST_HALT = 2'b01,
		SCS_ST_WAKE = 2'b11
	} scs_state_t;
endpackage : scs_pkg

/* File: core/scs_clock_select.sv */
// System clock source selection with AHB-Lite control registers
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select import scs_pkg::*; #(
	parameter bit HIGH_FROM_CRYSTAL = 1'b0,
	parameter bit SUB_FROM_CRYSTAL = 1'b0,
	parameter bit TBC_FROM_CRYSTAL = 1'b0,
	parameter int DIV_W = 6
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic slow_crystal_osc_i,
	input wire logic slow_rc_osc_i,
	input wire logic halt_i,
	input wire logic wake_i,
	input wire logic system_clock_on_i,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o,
	output logic substitute_clock_o,
	output logic timebase_clock_o,
	output logic fast_osc_enable_o,
	output logic slow_crystal_lowpower_select_o,
	output logic slow_crystal_pins_osc_o,
	output logic slow_osc_ready_flag_o,
	output logic [1:0] halt_state_o
);
	if (DIV_W != 6) begin : g_check
		$error("DIV_W must be 6 for divide by 2 to 64");
	end

	// Mask of low divider bits that must all be ones for a tick
	function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] code);
		logic [DIV_W-1:0] m;
		m = '0;
		unique case (code)
			3'h2: m = 6'h3f;
			3'h3: m = 6'h1f;
			3'h4: m = 6'h0f;
			3'h5: m = 6'h07;
			3'h6: m = 6'h03;
			3'h7: m = 6'h01;
			3'h0, 3'h1: m = 6'h00;
		endcase
		return m;
	endfunction : div_mask

	// Substitute clock chosen when fast select is low and code is 000/001
	function automatic logic uses_sub(input logic [3:0] sel);
		return !sel[3] && (sel[2:1] == 2'h0);
	endfunction : uses_sub

	logic xt_s1_reg, xt_s2_reg, xt_s3_reg;
	logic rc_s1_reg, rc_s2_reg, rc_s3_reg;
	logic [2:0] cks_reg, cks_next;
	logic fsten_reg, fsten_next;
	logic idlen_reg, idlen_next;
	logic high_low_clock_select_reg, high_low_clock_select_next;
	logic lp_reg, lp_next;
	logic pin_reg, pin_next;
	logic slow_rdy_reg, slow_rdy_next;
	logic fast_rdy_reg, fast_rdy_next;
	logic [7:0] scnt_reg, scnt_next;
	logic [7:0] fcnt_reg, fcnt_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [3:0] act_reg, act_next;
	scs_state_t state_reg, state_next;
	logic a_act_reg, a_act_next;
	logic a_wr_reg, a_wr_next;
	logic [7:0] a_addr_reg, a_addr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic cpu_en_reg, cpu_en_next;
	logic per_en_reg, per_en_next;
	logic sub_tick_reg, sub_tick_next;
	logic tb_tick_reg, tb_tick_next;
	logic fast_on_reg, fast_on_next;
	logic xt_edge, rc_edge, sub_edge, sys_tick, take;
	logic [7:0] addr_now;

	always_comb begin
		// Crystal pins serve as I/O unless routed to the oscillator
		xt_edge = xt_s2_reg && !xt_s3_reg && pin_reg;
		rc_edge = rc_s2_reg && !rc_s3_reg;
		sub_edge = SUB_FROM_CRYSTAL ? xt_edge : rc_edge;
		take = hsel_i && htrans_i[1] && hready_i;
		addr_now = haddr_i[7:0];
		// Undivided fast clock ticks every cycle once it is stable
		if (act_reg[3]) begin
			sys_tick = fast_rdy_reg;
		end else if (uses_sub(act_reg)) begin
			sys_tick = sub_edge && slow_rdy_reg;
		end else begin
			sys_tick = fast_rdy_reg &&
				((div_reg & div_mask(act_reg[2:0])) ==
				div_mask(act_reg[2:0]));
		end
	end

	always_comb begin
		cks_next = cks_reg;
		fsten_next = fsten_reg;
		idlen_next = idlen_reg;
		high_low_clock_select_next = high_low_clock_select_reg;
		lp_next = lp_reg;
		pin_next = pin_reg;
		a_act_next = take;
		a_wr_next = take && hwrite_i;
		a_addr_next = take ? addr_now : a_addr_reg;
		rdata_next = rdata_reg;
		if (a_act_reg && a_wr_reg) begin
			unique case (a_addr_reg)
				SCS_SYSMODE_OFS: begin
					cks_next = hwdata_i[SCS_CKS_LSB +: 3];
					fsten_next = hwdata_i[SCS_FSTEN_BIT];
					idlen_next = hwdata_i[SCS_IDLEN_BIT];
					high_low_clock_select_next = hwdata_i[SCS_HIGH_LOW_CLOCK_SELECT_BIT];
				end
				SCS_TIMEBASE_OFS: lp_next = hwdata_i[SCS_LOWPOWER_BIT];
				SCS_PINSHARE_OFS: pin_next = hwdata_i[SCS_PINXTAL_BIT];
				default: ;
			endcase
		end
		// Read data is fetched in the address phase to stay zero-wait
		if (take && !hwrite_i) begin
			rdata_next = '0;
			unique case (addr_now)
				SCS_SYSMODE_OFS: begin
					rdata_next[SCS_CKS_LSB +: 3] = cks_next;
					rdata_next[SCS_FSTEN_BIT] = fsten_next;
					rdata_next[SCS_SLOWRDY_BIT] = slow_rdy_reg;
					rdata_next[SCS_FASTRDY_BIT] = fast_rdy_reg;
					rdata_next[SCS_IDLEN_BIT] = idlen_next;
					rdata_next[SCS_HIGH_LOW_CLOCK_SELECT_BIT] = high_low_clock_select_next;
				end
				SCS_TIMEBASE_OFS: rdata_next[SCS_LOWPOWER_BIT] = lp_next;
				SCS_PINSHARE_OFS: rdata_next[SCS_PINXTAL_BIT] = pin_next;
				default: ;
			endcase
		end
	end

	always_comb begin
		div_next = div_reg + 1'b1;
		act_next = act_reg;
		// New selection lands only where every ratio starts a period
		if (&div_reg) begin
			act_next = {high_low_clock_select_reg, cks_reg};
		end
		state_next = state_reg;
		unique case (state_reg)
			SCS_ST_RUN: if (halt_i) state_next = SCS_ST_HALT;
			SCS_ST_HALT: if (wake_i) state_next = SCS_ST_WAKE;
			SCS_ST_WAKE: begin
				if (uses_sub(act_reg) ? slow_rdy_reg : fast_rdy_reg) begin
					state_next = SCS_ST_RUN;
				end
			end
			default: state_next = SCS_ST_RUN;
		endcase
		// Fast oscillator stops while the substitute clock drives things
		fast_on_next = (state_reg == SCS_ST_RUN && !uses_sub(act_reg)) ||
			(state_reg == SCS_ST_HALT && idlen_reg && system_clock_on_i &&
			!uses_sub(act_reg)) ||
			(state_reg == SCS_ST_WAKE && !uses_sub(act_reg));
		fcnt_next = fcnt_reg;
		fast_rdy_next = fast_rdy_reg;
		if (!fast_on_reg) begin
			fcnt_next = '0;
			fast_rdy_next = 1'b0;
		end else if (!fast_rdy_reg) begin
			fcnt_next = fcnt_reg + 1'b1;
			if (fcnt_next == (HIGH_FROM_CRYSTAL ? SCS_FAST_XTAL_READY_CYC :
				SCS_FAST_RC_READY_CYC)) begin
				fast_rdy_next = 1'b1;
			end
		end
		scnt_next = scnt_reg;
		slow_rdy_next = slow_rdy_reg;
		// Deep sleep drops the ready flag; it recounts after wake-up
		if (state_reg == SCS_ST_HALT && !idlen_reg) begin
			scnt_next = '0;
			slow_rdy_next = 1'b0;
		end else if (!slow_rdy_reg && sub_edge) begin
			scnt_next = scnt_reg + 1'b1;
			if (scnt_next == (SUB_FROM_CRYSTAL ? SCS_SLOW_XTAL_READY_TICKS :
				SCS_SLOW_RC_READY_TICKS)) begin
				slow_rdy_next = 1'b1;
			end
		end
		cpu_en_next = 1'b0;
		unique case (state_reg)
			SCS_ST_RUN: begin
				// A halt request swallows the tick due in its own cycle
				cpu_en_next = sys_tick && !halt_i;
			end
			SCS_ST_WAKE: begin
				// Early run on the substitute clock until fast is stable
				if (fsten_reg && HIGH_FROM_CRYSTAL && !uses_sub(act_reg)) begin
					cpu_en_next = sub_edge && slow_rdy_reg;
				end
			end
			SCS_ST_HALT: cpu_en_next = 1'b0;
			default: cpu_en_next = 1'b0;
		endcase
		per_en_next = (state_reg != SCS_ST_HALT || (idlen_reg && system_clock_on_i))
			&& sys_tick;
		sub_tick_next = sub_edge;
		tb_tick_next = TBC_FROM_CRYSTAL ? xt_edge : rc_edge;
	end

	always_ff @(posedge clk_i) begin
		// Pin inputs pass two stages before the edge detector reads them
		xt_s1_reg <= slow_crystal_osc_i;
		xt_s2_reg <= xt_s1_reg;
		rc_s1_reg <= slow_rc_osc_i;
		rc_s2_reg <= rc_s1_reg;
		if (reset_i) begin
			xt_s3_reg <= 1'b0;
			rc_s3_reg <= 1'b0;
			cks_reg <= SCS_CKS_RESET;
			fsten_reg <= SCS_FSTEN_RESET;
			idlen_reg <= SCS_IDLEN_RESET;
			high_low_clock_select_reg <= SCS_HIGH_LOW_CLOCK_SELECT_RESET;
			lp_reg <= SCS_LOWPOWER_RESET;
			pin_reg <= SCS_PINXTAL_RESET;
			slow_rdy_reg <= 1'b0;
			fast_rdy_reg <= 1'b0;
			scnt_reg <= '0;
			fcnt_reg <= '0;
			div_reg <= '0;
			act_reg <= {SCS_HIGH_LOW_CLOCK_SELECT_RESET, SCS_CKS_RESET};
			state_reg <= SCS_ST_RUN;
			a_act_reg <= 1'b0;
			a_wr_reg <= 1'b0;
			a_addr_reg <= '0;
			rdata_reg <= '0;
			cpu_en_reg <= 1'b0;
			per_en_reg <= 1'b0;
			sub_tick_reg <= 1'b0;
			tb_tick_reg <= 1'b0;
			fast_on_reg <= 1'b0;
		end else begin
			xt_s3_reg <= xt_s2_reg;
			rc_s3_reg <= rc_s2_reg;
			cks_reg <= cks_next;
			fsten_reg <= fsten_next;
			idlen_reg <= idlen_next;
			high_low_clock_select_reg <= high_low_clock_select_next;
			lp_reg <= lp_next;
			pin_reg <= pin_next;
			slow_rdy_reg <= slow_rdy_next;
			fast_rdy_reg <= fast_rdy_next;
			scnt_reg <= scnt_next;
			fcnt_reg <= fcnt_next;
			div_reg <= div_next;
			act_reg <= act_next;
			state_reg <= state_next;
			a_act_reg <= a_act_next;
			a_wr_reg <= a_wr_next;
			a_addr_reg <= a_addr_next;
			rdata_reg <= rdata_next;
			cpu_en_reg <= cpu_en_next;
			per_en_reg <= per_en_next;
			sub_tick_reg <= sub_tick_next;
			tb_tick_reg <= tb_tick_next;
			fast_on_reg <= fast_on_next;
		end
	end

	// Single slave with no wait states, so ready is a constant flop
	logic ready_reg;
	// Unmapped addresses still answer OKAY and read as zero
	logic resp_reg;
	always_ff @(posedge clk_i) begin
		ready_reg <= 1'b1;
		resp_reg <= 1'b0;
	end

	assign hrdata_o = rdata_reg;
	assign hreadyout_o = ready_reg;
	assign hresp_o = resp_reg;
	assign cpu_clk_en_o = cpu_en_reg;
	assign periph_clk_en_o = per_en_reg;
	assign substitute_clock_o = sub_tick_reg;
	assign timebase_clock_o = tb_tick_reg;
	assign fast_osc_enable_o = fast_on_reg;
	assign slow_crystal_lowpower_select_o = lp_reg;
	assign slow_crystal_pins_osc_o = pin_reg;
	assign slow_osc_ready_flag_o = slow_rdy_reg;
	assign halt_state_o = state_reg;
endmodule : scs_clock_select
`default_nettype wire

/* File: sim/scs_clock_select_monitor.sv */
// Port checker for the system clock source select block
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_mon import scs_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic halt_i,
	input wire logic wake_i,
	input wire logic cpu_clk_en_o,
	input wire logic substitute_clock_o,
	input wire logic slow_crystal_lowpower_select_o,
	input wire logic slow_crystal_pins_osc_o,
	input wire logic slow_osc_ready_flag_o,
	input wire logic [1:0] halt_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic take;
	logic wr_lp;
	logic wr_pin;
	assign take = hsel_i && htrans_i[1] && hready_i;
	assign wr_lp = take && hwrite_i && haddr_i[7:0] == SCS_TIMEBASE_OFS;
	assign wr_pin = take && hwrite_i && haddr_i[7:0] == SCS_PINSHARE_OFS;
	chk_lp_reset: assert property (
		$past(reset_i) |-> !slow_crystal_lowpower_select_o)
		else $error("low-power bit not cleared by reset");
	chk_lp_write: assert property (
		$changed(slow_crystal_lowpower_select_o) && !$past(reset_i)
		|-> $past(wr_lp, 2)) else $error("low-power bit moved unasked");
	chk_pin_write: assert property (
		$changed(slow_crystal_pins_osc_o) && !$past(reset_i)
		|-> $past(wr_pin, 2)) else $error("pin share moved unasked");
	chk_bus_okay: assert property (
		!hresp_o && hreadyout_o) else $error("bus answer not ready okay");
	chk_rdata_hold: assert property (
		!$past(reset_i) && !$past(take && !hwrite_i) |-> $stable(hrdata_o))
		else $error("read data moved without a read");
	chk_halt_enter: assert property (
		halt_state_o == SCS_ST_RUN && halt_i |=> halt_state_o == SCS_ST_HALT)
		else $error("halt request not taken");
	chk_halt_cpu: assert property (
		halt_state_o == SCS_ST_HALT |-> !cpu_clk_en_o)
		else $error("cpu tick while halted");
	chk_wake_step: assert property (
		halt_state_o == SCS_ST_HALT && wake_i |=> halt_state_o == SCS_ST_WAKE)
		else $error("wake request not taken");
	chk_sub_ready: assert property (
		$rose(slow_osc_ready_flag_o) |-> substitute_clock_o)
		else $error("slow ready rose off a slow tick");
endmodule : scs_clock_select_mon
bind scs_clock_select scs_clock_select_mon u_mon (.clk_i, .reset_i, .hsel_i,
	.haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o,
	.hresp_o, .halt_i, .wake_i, .cpu_clk_en_o, .substitute_clock_o,
	.slow_crystal_lowpower_select_o, .slow_crystal_pins_osc_o,
	.slow_osc_ready_flag_o, .halt_state_o);
`default_nettype wire

/* File: sim/scs_clock_select_tb.sv */
// Self-checking bench for the system clock source select block
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select_tb import scs_pkg::*;;
	logic clk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0, halt_i = 0;
	logic wake_i = 0, system_clock_on_i = 0, rd_ph = 0;
	logic slow_crystal_osc_i = 0, slow_rc_osc_i = 0;
	logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
	logic [1:0] htrans_i = 0, halt_state_o;
	logic hreadyout_o, hresp_o, cpu_clk_en_o, periph_clk_en_o;
	logic substitute_clock_o, timebase_clock_o, fast_osc_enable_o;
	logic slow_crystal_lowpower_select_o, slow_crystal_pins_osc_o;
	logic slow_osc_ready_flag_o;
	logic [31:0] exp_q[$];
	int failures = 0, check_count = 0, cyc = 0, seed = 49126, n;
	scs_clock_select DUT (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
		.hrdata_o, .hreadyout_o, .hresp_o, .slow_crystal_osc_i,
		.slow_rc_osc_i, .halt_i, .wake_i, .system_clock_on_i, .cpu_clk_en_o,
		.periph_clk_en_o, .substitute_clock_o, .timebase_clock_o,
		.fast_osc_enable_o, .slow_crystal_lowpower_select_o,
		.slow_crystal_pins_osc_o, .slow_osc_ready_flag_o, .halt_state_o);
	initial forever #12.5 clk_i = ~clk_i;
	// Slow oscillators at one sixteenth of the bus clock keep runs short
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7) slow_rc_osc_i <= ~slow_rc_osc_i;
		if (cyc % 8 == 3) slow_crystal_osc_i <= ~slow_crystal_osc_i;
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	always @(posedge clk_i) if (rd_ph && hreadyout_o === 1'b1)
		check(hrdata_o, exp_q.pop_front());
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Read data is expected in the queue before the address phase goes out
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		if (!w) exp_q.push_back(d);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= w ? d : 32'h0;
		rd_ph <= !w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		rd_ph <= 1'b0;
	endtask : xfer
	task automatic count(input int k, input int sel, output int c);
		logic pick;
		c = 0;
		repeat (k) begin
			@(posedge clk_i);
			pick = sel == 3 ? substitute_clock_o : sel == 2 ? timebase_clock_o :
				sel == 1 ? periph_clk_en_o : cpu_clk_en_o;
			c += (pick === 1'b1);
		end
	endtask : count
	task automatic req(input bit h);
		if (h) halt_i <= 1'b1;
		else wake_i <= 1'b1;
		@(posedge clk_i);
		halt_i <= 1'b0;
		wake_i <= 1'b0;
		for (int i = 0; i < 500 && !h && halt_state_o !== SCS_ST_RUN; i++)
			@(posedge clk_i);
	endtask : req
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		xfer(SCS_TIMEBASE_OFS, 0, 32'h0);
		xfer(SCS_PINSHARE_OFS, 0, 32'h0);
		xfer(8'h0c, 1, 32'hff);
		xfer(8'h0c, 0, 32'h0);
		repeat (300) @(posedge clk_i);
		xfer(SCS_SYSMODE_OFS, 0, 32'h0f);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			n = $random(seed);
			xfer(SCS_TIMEBASE_OFS, 1, n);
			xfer(SCS_TIMEBASE_OFS, 0, n & 1);
			check(slow_crystal_lowpower_select_o, n & 1);
			xfer(SCS_PINSHARE_OFS, 1, ~n);
			xfer(SCS_PINSHARE_OFS, 0, ~n & 1);
			check(slow_crystal_pins_osc_o, ~n & 1);
		end
		count(128, 2, n);
		check(n, 8);
		count(128, 3, n);
		check(n, 8);
		$display("control bits done");
		// Index 8 returns to the undivided fast clock
		for (int k = 0; k < 9; k++) begin
			xfer(SCS_SYSMODE_OFS, 1, k == 8 ? 32'h03 : {k[2:0], 5'h02});
			repeat (140) @(posedge clk_i);
			count(128, 0, n);
			check(n, k == 8 ? 128 : k < 2 ? 8 : 128 >> (8 - k));
			check(fast_osc_enable_o, k > 1);
		end
		$display("divider codes done");
		system_clock_on_i <= 1'b1;
		req(1);
		count(32, 0, n);
		check(n, 0);
		check(halt_state_o, SCS_ST_HALT);
		count(32, 1, n);
		check(n, 32);
		req(0);
		check(halt_state_o, SCS_ST_RUN);
		count(32, 0, n);
		check(n, 32);
		xfer(SCS_SYSMODE_OFS, 1, 32'h01);
		req(1);
		repeat (4) @(posedge clk_i);
		check(slow_osc_ready_flag_o, 0);
		check(fast_osc_enable_o, 0);
		req(0);
		repeat (64) @(posedge clk_i);
		check(slow_osc_ready_flag_o, 1);
		$display("halt and wake done");
		tally_and_finish();
	end
endmodule : scs_clock_select_tb
`default_nettype wire
